// ==== output_stream_sequencer_regs.vh ====
// Register map, field positions and timing constants of the output stream sequencer
`ifndef OUTPUT_STREAM_SEQUENCER_REGS_VH
`define OUTPUT_STREAM_SEQUENCER_REGS_VH

// Word offsets (byte address = 4 x index)
`define REG_CTRL        4'h0
`define REG_CFG         4'h1
`define REG_LIST        4'h2
`define REG_DIVISOR     4'h3
`define REG_STOP_COUNT  4'h4
`define REG_SINGLE      4'h5
`define REG_FIFO_DATA   4'h6
`define REG_STATUS      4'h7
`define REG_BUF_LEN     4'h8
`define REG_CONV0       4'h9
`define REG_CONV1       4'hA
`define REG_DOUT        4'hB

// Control bits (write one to act)
`define CTRL_START      0
`define CTRL_SOFT_TRIG  1
`define CTRL_ORDERLY    2
`define CTRL_ABRUPT     3
`define CTRL_FIFO_CLR   4
`define CTRL_ARM        5

// Configuration fields
`define CFG_WRAP        0
`define CFG_EXT_CLK     1
`define CFG_EXT_TRIG    2
`define CFG_TRIG_FALL   3

// List fields: count in [1:0], entry codes in [3:2], [5:4], [7:6]
`define LIST_CODE_W     2
`define CODE_CONV0      2'h0
`define CODE_CONV1      2'h1
`define CODE_DOUT       2'h2

// Single-value fields
`define SV_DATA_LSB     0
`define SV_CHAN_LSB     16
`define SV_LINE_LSB     20
`define SV_BIT_MODE     24
`define SV_GO           31
`define SV_CHAN_DOUT    3'h2

// Status bits
`define ST_RUN          0
`define ST_ARMED        1
`define ST_UNDERFLOW    2
`define ST_OVERSAMPLE   3
`define ST_BUF_DONE     4
`define ST_FIFO_FULL    5
`define ST_FIFO_EMPTY   6

// Wait clocks before each list entry loads; one entry takes this many clocks plus one
`define LOAD_CYCLES     2'h1
`define DOUT_RESET      8'h00
`define CONV_MID        16'h8000

`endif

// ==== output_stream_sequencer.v ====
// Paced output sequencer: converter/port list loading, triggers, stops and errors
`timescale 1ns/100ps
`default_nettype none
`include "output_stream_sequencer_regs.vh"

// Contract
// - single value writes one channel, unstoppable
// - continuous idles until selected trigger
// - buffer words interleave by list position
// - all list channels update together per tick
// - paced mode runs until data exhausted/stop
// - orderly stop finishes count, ignores triggers
// - abrupt stop halts at once
// - host loads pattern; device plays at rate
// - waveform wraps to first FIFO location
// - converter words are offset binary
// - event after each whole buffer output
// - underflow when tick finds FIFO empty
// - outputs hold last loaded value
// - over-sample when tick arrives while loading
// - digital port is eight lines, one value
// - digital lines reset to zero
// - single-value access to one digital line
// - list codes 0,1,2, ascending, max three
// - external trigger edge selectable; soft immediate
// - internal pacing programmable; external rising edge
// - converters double-buffered; reset keeps them
module output_stream_sequencer #(
  parameter FIFO_AW = 10,
  parameter DIV_W   = 26
) (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Avalon-MM slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // External pins
  input  wire        ext_clk_pin,
  input  wire        ext_trig_pin,
  // Outputs
  output reg  [15:0] first_converter = `CONV_MID,
  output reg  [15:0] second_converter = `CONV_MID,
  output reg  [7:0]  dout,
  output reg         buf_done_pulse
);

  localparam S_IDLE  = 4'b0001;
  localparam S_ARMED = 4'b0010;
  localparam S_RUN   = 4'b0100;
  localparam S_LOAD  = 4'b1000;
  localparam DEPTH   = 1 << FIFO_AW;

  // Two-cycle answer: first cycle of a request waits, second completes
  reg ack;
  assign waitrequest = (read | write) & ~ack;
  wire acc_wr = write & ack;

  reg [3:0]         state;
  reg [5:0]         cfg;
  reg [7:0]         list;
  reg [DIV_W-1:0]   divisor;
  reg [31:0]        stop_count;
  reg [31:0]        buf_len;
  reg               underflow;
  reg               oversample;
  reg               buf_done;
  reg               orderly;
  reg [15:0]        mem [0:DEPTH-1];
  reg [FIFO_AW:0]   wr_ptr;
  reg [FIFO_AW:0]   rd_ptr;
  reg [FIFO_AW:0]   play_ptr;
  reg [DIV_W-1:0]   div_cnt;
  reg [1:0]         entry;
  reg [1:0]         load_cnt;
  reg [15:0]        stage0;
  reg [15:0]        stage1;
  reg [7:0]         stage_d;
  reg [31:0]        sent;
  reg [31:0]        buf_cnt;
  reg [2:0]         clk_sync;
  reg [2:0]         trig_sync;

  function [1:0] entry_code;
    input [7:0] l;
    input [1:0] i;
    begin
      entry_code = l[2*i+2 +: 2];
    end
  endfunction

  wire [FIFO_AW:0] fill = wr_ptr - rd_ptr;
  wire fifo_full  = (fill == DEPTH[FIFO_AW:0]);
  wire fifo_empty = (fill == {(FIFO_AW+1){1'b0}});
  wire wrap_mode  = cfg[`CFG_WRAP];
  wire has_word   = wrap_mode ? (play_ptr != wr_ptr) : ~fifo_empty;
  wire [FIFO_AW:0] src_ptr = wrap_mode ? play_ptr : rd_ptr;
  wire [15:0] word = mem[src_ptr[FIFO_AW-1:0]];

  // external clock rising edge, after two-flop sync
  wire ext_tick = clk_sync[1] & ~clk_sync[2];
  wire int_tick = (div_cnt == {DIV_W{1'b0}});
  wire tick = cfg[`CFG_EXT_CLK] ? ext_tick : int_tick;
  wire rise = trig_sync[1] & ~trig_sync[2];
  wire fall = ~trig_sync[1] & trig_sync[2];
  wire ext_trig = cfg[`CFG_TRIG_FALL] ? fall : rise;
  wire soft_trig = acc_wr && address == `REG_CTRL && writedata[`CTRL_SOFT_TRIG];
  wire trig = cfg[`CFG_EXT_TRIG] ? ext_trig : soft_trig;
  wire ctrl_wr = acc_wr && address == `REG_CTRL;
  wire fifo_wr = acc_wr && address == `REG_FIFO_DATA && !fifo_full;
  wire [1:0] last_entry = list[1:0] - 2'h1;

  always @(posedge clk) begin
    clk_sync  <= {clk_sync[1:0], ext_clk_pin};
    trig_sync <= {trig_sync[1:0], ext_trig_pin};
    if (fifo_wr)
      mem[wr_ptr[FIFO_AW-1:0]] <= writedata[15:0];
  end

  always @(posedge clk) begin
    if (srst)
      ack <= 1'b0;
    else
      ack <= (read | write) & ~ack;
  end

  always @(posedge clk) begin
    if (srst)
      readdata <= 32'h0000_0000;
    else if (read & ~ack) begin
      if (address == `REG_CFG)
        readdata <= {26'h0, cfg};
      else if (address == `REG_LIST)
        readdata <= {24'h0, list};
      else if (address == `REG_DIVISOR)
        readdata <= {{(32-DIV_W){1'b0}}, divisor};
      else if (address == `REG_STOP_COUNT)
        readdata <= stop_count;
      else if (address == `REG_STATUS)
        readdata <= {25'h0, fifo_empty, fifo_full, buf_done, oversample, underflow,
                     state == S_ARMED, (state == S_RUN) | (state == S_LOAD)};
      else if (address == `REG_BUF_LEN)
        readdata <= buf_len;
      else if (address == `REG_CONV0)
        readdata <= {16'h0, first_converter};
      else if (address == `REG_CONV1)
        readdata <= {16'h0, second_converter};
      else if (address == `REG_DOUT)
        readdata <= {24'h0, dout};
      else
        readdata <= 32'h0000_0000;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= S_IDLE;
      cfg <= 6'h00;
      list <= 8'h00;
      divisor <= {DIV_W{1'b0}};
      stop_count <= 32'h0000_0000;
      buf_len <= 32'h0000_0000;
      underflow <= 1'b0;
      oversample <= 1'b0;
      buf_done <= 1'b0;
      buf_done_pulse <= 1'b0;
      orderly <= 1'b0;
      wr_ptr <= {(FIFO_AW+1){1'b0}};
      rd_ptr <= {(FIFO_AW+1){1'b0}};
      play_ptr <= {(FIFO_AW+1){1'b0}};
      div_cnt <= {DIV_W{1'b0}};
      entry <= 2'h0;
      load_cnt <= 2'h0;
      stage0 <= 16'h0000;
      stage1 <= 16'h0000;
      stage_d <= `DOUT_RESET;
      sent <= 32'h0000_0000;
      buf_cnt <= 32'h0000_0000;
      dout <= `DOUT_RESET;
    end else begin
      buf_done_pulse <= 1'b0;
      if (fifo_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (acc_wr && address == `REG_CFG)
        cfg <= writedata[5:0];
      if (acc_wr && address == `REG_LIST)
        list <= writedata[7:0];
      if (acc_wr && address == `REG_DIVISOR)
        divisor <= writedata[DIV_W-1:0];
      if (acc_wr && address == `REG_STOP_COUNT)
        stop_count <= writedata;
      if (acc_wr && address == `REG_BUF_LEN)
        buf_len <= writedata;
      // write one to clear; a same-cycle set wins below
      if (acc_wr && address == `REG_STATUS) begin
        underflow <= underflow & ~writedata[`ST_UNDERFLOW];
        oversample <= oversample & ~writedata[`ST_OVERSAMPLE];
        buf_done <= buf_done & ~writedata[`ST_BUF_DONE];
      end
      if (ctrl_wr && writedata[`CTRL_FIFO_CLR] && state == S_IDLE) begin
        wr_ptr <= {(FIFO_AW+1){1'b0}};
        rd_ptr <= {(FIFO_AW+1){1'b0}};
        play_ptr <= {(FIFO_AW+1){1'b0}};
      end
      // single value write, needs no clock, trigger or FIFO
      if (acc_wr && address == `REG_SINGLE && writedata[`SV_GO] && state == S_IDLE) begin
        if (writedata[`SV_BIT_MODE])
          dout[writedata[`SV_LINE_LSB +: 3]] <= writedata[`SV_DATA_LSB];
        else if (writedata[`SV_CHAN_LSB +: 3] == `SV_CHAN_DOUT)
          dout <= writedata[`SV_DATA_LSB +: 8];
      end
      if (state != S_IDLE)
        div_cnt <= int_tick ? divisor : div_cnt - 1'b1;
      // stop request kept while running or loading
      if (ctrl_wr && writedata[`CTRL_ORDERLY] && (state == S_RUN || state == S_LOAD))
        orderly <= 1'b1;
      case (state)
        S_IDLE: begin
          // only an explicit arm leaves idle
          if (ctrl_wr && writedata[`CTRL_ARM] && list[1:0] != 2'h0) begin
            state <= S_ARMED;
            orderly <= 1'b0;
            sent <= 32'h0000_0000;
            buf_cnt <= 32'h0000_0000;
            play_ptr <= rd_ptr;
          end
        end
        S_ARMED: begin
          if (ctrl_wr && writedata[`CTRL_ABRUPT])
            state <= S_IDLE;
          else if (trig) begin
            state <= S_RUN;
            div_cnt <= {DIV_W{1'b0}};
          end
        end
        S_RUN: begin
          if (ctrl_wr && writedata[`CTRL_ABRUPT])
            state <= S_IDLE;
          else if (orderly && sent >= stop_count)
            state <= S_IDLE;
          else if (tick) begin
            if (!has_word) begin
              // empty at tick: underflow, output ends
              underflow <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_LOAD;
              entry <= 2'h0;
              load_cnt <= `LOAD_CYCLES;
              // unlisted channels reload their own value
              {stage0, stage1, stage_d} <= {first_converter, second_converter, dout};
            end
          end
        end
        S_LOAD: begin
          if (ctrl_wr && writedata[`CTRL_ABRUPT])
            state <= S_IDLE;
          else if (tick) begin
            // tick while loading: flag and halt
            oversample <= 1'b1;
            state <= S_IDLE;
          end else if (load_cnt != 2'h0)
            load_cnt <= load_cnt - 1'b1;
          else if (!has_word) begin
            underflow <= 1'b1;
            state <= S_IDLE;
          end else begin
            // word routed by list entry code
            if (entry_code(list, entry) == `CODE_CONV0)
              stage0 <= word;
            else if (entry_code(list, entry) == `CODE_CONV1)
              stage1 <= word;
            else
              stage_d <= word[7:0];
            if (wrap_mode)
              play_ptr <= (play_ptr + 1'b1 == wr_ptr) ? rd_ptr : play_ptr + 1'b1;
            else
              rd_ptr <= rd_ptr + 1'b1;
            sent <= sent + 32'h1;
            if (buf_cnt + 32'h1 == buf_len) begin
              buf_cnt <= 32'h0000_0000;
              buf_done <= 1'b1;
              buf_done_pulse <= 1'b1;
            end else
              buf_cnt <= buf_cnt + 32'h1;
            load_cnt <= `LOAD_CYCLES;
            if (entry == last_entry) begin
              state <= S_RUN;
              entry <= 2'h0;
            end else
              entry <= entry + 2'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
      // all staged values applied together; held otherwise
      if (state == S_LOAD && load_cnt == 2'h0 && has_word && !tick && entry == last_entry
          && !(ctrl_wr && writedata[`CTRL_ABRUPT])) begin
        dout <= (entry_code(list, entry) == `CODE_DOUT) ? word[7:0] : stage_d;
      end
    end
  end

  // double buffer load; no reset, so values survive it
  always @(posedge clk) begin
    if (!srst && acc_wr && address == `REG_SINGLE && writedata[`SV_GO] && state == S_IDLE
        && !writedata[`SV_BIT_MODE] && writedata[`SV_CHAN_LSB +: 3] != `SV_CHAN_DOUT) begin
      if (writedata[`SV_CHAN_LSB +: 3] == {1'b0, `CODE_CONV1})
        second_converter <= writedata[15:0];
      else
        first_converter <= writedata[15:0];
    end else if (!srst && state == S_LOAD && load_cnt == 2'h0 && has_word && !tick
                 && entry == last_entry && !(ctrl_wr && writedata[`CTRL_ABRUPT])) begin
      first_converter <= (entry_code(list, entry) == `CODE_CONV0) ? word : stage0;
      second_converter <= (entry_code(list, entry) == `CODE_CONV1) ? word : stage1;
    end
  end

endmodule
`default_nettype wire

// ==== output_stream_sequencer_monitor.sv ====
// Port checks for the output stream sequencer
`timescale 1ns/100ps
`default_nettype none
module output_stream_sequencer_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Outputs
  input wire logic [15:0] first_converter,
  input wire logic [15:0] second_converter,
  input wire logic [7:0]  dout,
  input wire logic        buf_done_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("request not held off in its first cycle");
  a_wait_second: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in its second cycle");
  a_unmapped_zero: assert property (read && !waitrequest && address > 4'hB |-> readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_read_hold: assert property (!$past(read) && !$past(srst) |-> $stable(readdata))
    else $error("read data moved without a read");
  a_dout_reset: assert property ($past(srst) |-> dout == 8'h00)
    else $error("digital port not low after reset");
  a_conv0_keep: assert property ($past(srst) |-> first_converter == $past(first_converter))
    else $error("reset disturbed first converter");
  a_conv1_keep: assert property ($past(srst) |-> second_converter == $past(second_converter))
    else $error("reset disturbed second converter");
  a_done_pulse: assert property (buf_done_pulse |=> !buf_done_pulse)
    else $error("buffer event longer than one cycle");
endmodule

bind output_stream_sequencer output_stream_sequencer_monitor u_mon (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .first_converter(first_converter),
  .second_converter(second_converter), .dout(dout), .buf_done_pulse(buf_done_pulse));
`default_nettype wire

// ==== sample_host.sv ====
// Host model: bus master that configures the block and streams sample words
`timescale 1ns/100ps
`default_nettype none
`include "output_stream_sequencer_regs.vh"
module sample_host (
  // Clock
  input wire logic         clk,
  // Bus
  input wire logic         waitrequest,
  input wire logic [31:0]  readdata,
  output var logic [3:0]   address,
  output var logic         read,
  output var logic         write,
  output var logic [31:0]  writedata,
  // Status
  output var logic         timed_out
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    timed_out = 1'b0;
  end

  // A slave that never answers must not hang the run
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    begin
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (waitrequest !== 1'b0 && n < 64);
      q = readdata;
      if (n >= 64) timed_out <= 1'b1;
      write <= 1'b0;
      read <= 1'b0;
    end
  endtask

  // words sent whole, in list order
  task automatic send(input logic [15:0] v);
    logic [31:0] q;
    xfer(1'b1, `REG_FIFO_DATA, {16'h0, v}, q);
  endtask
endmodule
`default_nettype wire

// ==== output_stream_sequencer_tb_top.sv ====
// Self-checking bench for the output stream sequencer
`timescale 1ns/100ps
`default_nettype none
`include "output_stream_sequencer_regs.vh"
module output_stream_sequencer_tb_top;
  logic        clk, srst, ext_clk_pin, ext_trig_pin;
  wire  [3:0]  address;
  wire         read, write, waitrequest, buf_done_pulse, timed_out;
  wire  [31:0] writedata, readdata;
  wire  [15:0] first_converter, second_converter;
  wire  [7:0]  dout;
  int          error_cnt, tests_run, done_cnt;
  logic [31:0] q;
  logic [39:0] s;
  logic [15:0] w [6];

  output_stream_sequencer DUT (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_clk_pin(ext_clk_pin), .ext_trig_pin(ext_trig_pin), .first_converter(first_converter),
    .second_converter(second_converter), .dout(dout), .buf_done_pulse(buf_done_pulse));
  sample_host host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .timed_out(timed_out));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (buf_done_pulse === 1'b1) done_cnt++;
  always @(posedge timed_out) begin
    error_cnt++;
    give_verdict;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  // Wait for the next output change, then compare all channels in that cycle
  task automatic step(input logic [15:0] a, input logic [15:0] b, input logic [7:0] c);
    int n;
    s = {first_converter, second_converter, dout};
    n = 0;
    while ({first_converter, second_converter, dout} === s && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      give_verdict;
    end
    check({first_converter, second_converter, dout}, {a, b, c});
  endtask
  // every channel shares one list, clock and trigger
  task automatic setup(input logic [31:0] list, input logic [31:0] cfg, input logic [31:0] dv);
    wr(`REG_CTRL, 32'h10);
    wr(`REG_CFG, cfg);
    wr(`REG_LIST, list);
    wr(`REG_DIVISOR, dv);
  endtask
  task automatic run(input int n);
    for (int i = 0; i < n; i++) host.send(w[i]);
    wr(`REG_CTRL, 32'h20);
  endtask
  task automatic ext_pulse;
    ext_clk_pin <= 1'b1;
    repeat (6) @(posedge clk);
    ext_clk_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    srst = 1'b1;
    ext_clk_pin = 1'b0;
    ext_trig_pin = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    done_cnt = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc(`REG_DOUT, 32'hFF, 32'h0);
    rdc(4'hF, 32'hFFFFFFFF, 32'h0);
    check(dout, 8'h00);
    $display("test reset finished");
    wr(`REG_SINGLE, 32'h8000_0000);
    step(16'h0000, 16'h8000, 8'h00);
    wr(`REG_SINGLE, 32'h8001_FFFF);
    step(16'h0000, 16'hFFFF, 8'h00);
    wr(`REG_SINGLE, 32'h8152_0001);
    step(16'h0000, 16'hFFFF, 8'h20);
    rdc(`REG_CONV1, 32'hFFFF, 32'hFFFF);
    $display("test single values finished");
    setup(32'h93, 32'h0, 32'd20);
    wr(`REG_BUF_LEN, 32'd6);
    w = '{16'h1111, 16'h2222, 16'h0033, 16'h4444, 16'h5555, 16'h0066};
    run(6);
    repeat (60) @(posedge clk);
    check({first_converter, second_converter, dout}, {16'h0, 16'hFFFF, 8'h20});
    wr(`REG_CTRL, 32'h2);
    step(16'h1111, 16'h2222, 8'h33);
    step(16'h4444, 16'h5555, 8'h66);
    repeat (60) @(posedge clk);
    rdc(`REG_STATUS, 32'h5, 32'h4);
    check({first_converter, second_converter, dout}, {16'h4444, 16'h5555, 8'h66});
    check(40'(done_cnt), 40'd1);
    wr(`REG_STATUS, 32'h1C);
    rdc(`REG_STATUS, 32'h4, 32'h0);
    $display("test paced list finished");
    setup(32'h01, 32'h1, 32'd20);
    w[0] = 16'h0A0A;
    w[1] = 16'hF00F;
    run(2);
    wr(`REG_CTRL, 32'h2);
    step(16'h0A0A, 16'h5555, 8'h66);
    step(16'hF00F, 16'h5555, 8'h66);
    step(16'h0A0A, 16'h5555, 8'h66);
    wr(`REG_CTRL, 32'h8);
    @(posedge clk);
    s = {first_converter, second_converter, dout};
    repeat (60) @(posedge clk);
    check({first_converter, second_converter, dout}, s);
    rdc(`REG_STATUS, 32'h1, 32'h0);
    wr(`REG_CTRL, 32'h2);
    repeat (60) @(posedge clk);
    check({first_converter, second_converter, dout}, s);
    $display("test waveform and abrupt stop finished");
    setup(32'h05, 32'hE, 32'd20);
    w[0] = 16'h7E57;
    run(1);
    ext_trig_pin <= 1'b1;
    ext_pulse;
    repeat (10) @(posedge clk);
    check({first_converter, second_converter, dout}, s);
    ext_trig_pin <= 1'b0;
    repeat (10) @(posedge clk);
    ext_pulse;
    repeat (20) @(posedge clk);
    check({first_converter, second_converter, dout}, {s[39:24], 16'h7E57, 8'h66});
    wr(`REG_CTRL, 32'h8);
    rdc(`REG_STATUS, 32'h1, 32'h0);
    $display("test external trigger finished");
    setup(32'h93, 32'h0, 32'd20);
    wr(`REG_STOP_COUNT, 32'd3);
    run(6);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_CTRL, 32'h4);
    step(16'h7E57, 16'hF00F, 8'h33);
    repeat (60) @(posedge clk);
    rdc(`REG_STATUS, 32'h5, 32'h0);
    wr(`REG_CTRL, 32'h2);
    repeat (60) @(posedge clk);
    check({first_converter, second_converter, dout}, {16'h7E57, 16'hF00F, 8'h33});
    $display("test orderly stop finished");
    setup(32'h93, 32'h0, 32'd0);
    run(6);
    wr(`REG_CTRL, 32'h2);
    repeat (40) @(posedge clk);
    rdc(`REG_STATUS, 32'h9, 32'h8);
    $display("test over-sample finished");
    give_verdict;
  end
endmodule
`default_nettype wire
